// *** bench/lbf_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`include "lbf_consts.svh"
module lbf_ctrl_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, core_reset, gt_reset, rxrst, tx_ena, tx_sop, tx_eop, tx_bctl;
   logic [31:0] tx_data, rx_data, last_q;
   logic tx_rdy, tx_ovf, tx_underflow, tx_burst_err, rx_ena, rx_sop, rx_eop, rx_err;
   logic rx_ovf, rx_crc24_err, hit;
   logic [3:0] lane_crc;
   logic [7:0] words_q, bctl_q, tx_chan;
   logic clk_stable = 1'b0, lock = 1'b0, sdv = 1'b0, stall = 1'b0;
   logic [6:0] inj = 7'h00;
   int err_count = 0;
   int samples_checked = 0;
   int wt = 0;
   always #2.5 pclk = ~pclk;
   lbf_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_reset(core_reset), .gt_reset(gt_reset),
      .transceiver_receive_reset(rxrst), .tx_ena(tx_ena), .tx_data(tx_data),
      .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_chan(tx_chan), .tx_bctl(tx_bctl), .tx_rdy(tx_rdy),
      .tx_ovf(tx_ovf), .tx_underflow(tx_underflow), .tx_burst_err(tx_burst_err),
      .rx_ena(rx_ena), .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop),
      .rx_err(rx_err), .rx_ovf(rx_ovf), .lane_crc_mismatch_flag(lane_crc),
      .rx_crc24_err(rx_crc24_err), .clk_stable(clk_stable),
      .clock_data_recovery_lock(lock), .serial_data_valid(sdv));
   lbf_dev_model dev (.pclk(pclk), .core_reset(core_reset), .stall(stall), .inj(inj),
      .tx_ena(tx_ena), .tx_data(tx_data), .tx_sop(tx_sop), .tx_eop(tx_eop),
      .tx_bctl(tx_bctl), .tx_rdy(tx_rdy), .tx_ovf(tx_ovf), .tx_underflow(tx_underflow),
      .tx_burst_err(tx_burst_err), .rx_ena(rx_ena), .rx_data(rx_data), .rx_sop(rx_sop),
      .rx_eop(rx_eop), .rx_err(rx_err), .rx_ovf(rx_ovf), .lane_crc_mismatch_flag(lane_crc),
      .rx_crc24_err(rx_crc24_err), .last_q(last_q), .words_q(words_q), .bctl_q(bctl_q));
   // ==========================================
   // report
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // ==========================================
   // apb master; pready, read data and error are taken at the edge that ends the access,
   // before that edge's flop updates land
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 200);
      rd = prdata;
      er = pslverr;
      wt = n;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk("pready", 1, 0);
         wrap_up();
      end
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : rdc
   task automatic wait_st(input logic [1:0] s);
      int n;
      n = 0;
      do begin
         apb(1'b0, `LBF_OFF_STATE, 32'h0);
         n++;
      end while (rd[1:0] !== s && n < 100);
      chk("state", {30'h0, s}, {30'h0, rd[1:0]});
      if (rd[1:0] !== s) wrap_up();
   endtask : wait_st
   // ==========================================
   // scenarios
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("core_reset", 1, {31'h0, core_reset & gt_reset});
      rdc("ctrl", `LBF_OFF_CTRL, 32'h0);
      rdc("maxb", `LBF_OFF_MAXB, {24'h0, `LBF_MAXB_RST});
      apb(1'b1, `LBF_OFF_MAXB, 32'h1);
      rdc("maxb min", `LBF_OFF_MAXB, {24'h0, `LBF_MAXB_RST});
      apb(1'b1, 12'h0fc, 32'h0);
      chk("pslverr", 1, {31'h0, er});
      apb(1'b1, `LBF_OFF_MAXB, 32'h5);
      rdc("maxb", `LBF_OFF_MAXB, 32'h5);
      apb(1'b1, `LBF_OFF_CTRL, 32'h1);
      repeat (40) @(posedge pclk);
      rdc("state", `LBF_OFF_STATE, 32'h0);
      clk_stable <= 1'b1;
      lock <= 1'b1;
      wait_st(2'd1);
      chk("rx reset", 1, {31'h0, rxrst & !core_reset});
      sdv <= 1'b1;
      wait_st(2'd2);
      apb(1'b1, `LBF_OFF_MAXB, 32'h7);
      rdc("maxb", `LBF_OFF_MAXB, 32'h5);
      stall <= 1'b1;
      apb(1'b1, `LBF_OFF_TXD, 32'ha5a50001);
      apb(1'b1, `LBF_OFF_TXC, 32'h105);
      repeat (8) @(posedge pclk);
      chk("held", 0, {24'h0, words_q});
      rdc("pend", `LBF_OFF_STATE, 32'ha);
      // a second word while one waits must stall the bus until tx ready returns
      fork
         begin
            repeat (4) @(posedge pclk);
            stall <= 1'b0;
         end
         apb(1'b1, `LBF_OFF_TXC, 32'h105);
      join
      chk("stall", 1, {31'h0, wt > 1});
      repeat (6) @(posedge pclk);
      chk("sent", 2, {24'h0, words_q});
      chk("data", 32'ha5a50001, last_q);
      chk("fields", 32'h105, {22'h0, tx_eop, tx_sop, tx_chan});
      // plain words after a start: a control word must appear before max 5
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, `LBF_OFF_TXC, (i == 6) ? 32'h200 : 32'h0);
      end
      repeat (6) @(posedge pclk);
      chk("bctl", 1, {24'h0, bctl_q});
      chk("words", 9, {24'h0, words_q});
      chk("fields", 32'h200, {22'h0, tx_eop, tx_sop, tx_chan});
      rdc("stat", `LBF_OFF_STAT, 32'h0);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, `LBF_OFF_STAT, 32'h3f);
         inj <= 7'h01 << i;
         @(posedge pclk);
         inj <= 7'h00;
         repeat (6) @(posedge pclk);
         if (i < 6) rdc("stat", `LBF_OFF_STAT, 32'h1 << i);
         else rdc("crc", `LBF_OFF_CRC, 32'h4);
         if (i == 3) rdc("rxi", `LBF_OFF_RXI, 32'h701);
         if (i == 3) rdc("rxd", `LBF_OFF_RXD, 32'h5a5a0003);
      end
      apb(1'b1, `LBF_OFF_STAT, 32'h3f);
      rdc("stat", `LBF_OFF_STAT, 32'h0);
      apb(1'b1, `LBF_OFF_CTRL, 32'h5);
      hit = 1'b0;
      repeat (12) begin
         @(negedge pclk);
         hit = hit | rxrst;
      end
      chk("rxrq", 1, {31'h0, hit});
      wait_st(2'd2);
      apb(1'b1, `LBF_OFF_CTRL, 32'h3);
      inj <= 7'h01;
      @(posedge pclk);
      inj <= 7'h00;
      wait_st(2'd0);
      wait_st(2'd2);
      lock <= 1'b0;
      wait_st(2'd0);
      wrap_up();
   end
endmodule : lbf_ctrl_tb_top

// *** bench/lbf_dev_model.sv ***
`timescale 1ns/100ps
// ==========================================
// device side: flags are pulsed by the bench or raised by real misuse
module lbf_dev_model (
   input wire logic pclk,
   input wire logic core_reset,
   input wire logic stall,
   input wire logic [6:0] inj,
   input wire logic tx_ena,
   input wire logic [31:0] tx_data,
   input wire logic tx_sop,
   input wire logic tx_eop,
   input wire logic tx_bctl,
   output logic tx_rdy,
   output logic tx_ovf,
   output logic tx_underflow,
   output logic tx_burst_err,
   output logic rx_ena,
   output logic [31:0] rx_data,
   output logic rx_sop,
   output logic rx_eop,
   output logic rx_err,
   output logic rx_ovf,
   output logic [3:0] lane_crc_mismatch_flag,
   output logic rx_crc24_err,
   output logic [31:0] last_q,
   output logic [7:0] words_q,
   output logic [7:0] bctl_q
);
   // all flags leave one flop, no combinational path back to the block
   always_ff @(posedge pclk) begin
      if (core_reset) begin
         {tx_rdy, tx_ovf, tx_underflow, tx_burst_err, rx_ena, rx_sop, rx_eop} <= 7'h00;
         {rx_err, rx_ovf, rx_crc24_err} <= 3'h0;
         lane_crc_mismatch_flag <= 4'h0;
         rx_data <= 32'h0;
         words_q <= 8'h00;
         bctl_q <= 8'h00;
         last_q <= 32'h0;
      end else begin
         tx_rdy <= !stall;
         tx_ovf <= inj[0] | (tx_ena & !tx_rdy);
         tx_underflow <= inj[1];
         tx_burst_err <= inj[2] | (tx_ena & tx_bctl & (tx_sop | tx_eop));
         // merged packet delivered as one errored word
         {rx_ena, rx_sop, rx_eop, rx_err} <= {4{inj[3]}};
         // fixed pattern so the captured rx word can be checked exactly
         rx_data <= inj[3] ? 32'h5a5a0003 : 32'h0;
         rx_ovf <= inj[4];
         rx_crc24_err <= inj[5];
         // marker on lane 2 only, so the crc register shows which lane flagged
         lane_crc_mismatch_flag <= inj[6] ? 4'h4 : 4'h0;
         if (tx_ena) begin
            words_q <= words_q + 8'h01;
            last_q <= tx_data;
            bctl_q <= bctl_q + {7'h00, tx_bctl};
         end
      end
   end
endmodule : lbf_dev_model

// *** hdl/lbf_consts.svh ***
`ifndef LBF_CONSTS_SVH
`define LBF_CONSTS_SVH
// ==========================================
// clock and timing
`define LBF_CLK_MHZ 200
`define LBF_RST_HOLD_NS 100
`define LBF_RST_HOLD_CYC ((`LBF_RST_HOLD_NS * `LBF_CLK_MHZ + 999) / 1000)
`define LBF_RXRST_NS 50
`define LBF_RXRST_CYC ((`LBF_RXRST_NS * `LBF_CLK_MHZ + 999) / 1000)
// ==========================================
// register offsets
`define LBF_OFF_CTRL 12'h000
`define LBF_OFF_MAXB 12'h004
`define LBF_OFF_TXD 12'h008
`define LBF_OFF_TXC 12'h00c
`define LBF_OFF_STAT 12'h010
`define LBF_OFF_STATE 12'h014
`define LBF_OFF_RXD 12'h018
`define LBF_OFF_RXI 12'h01c
`define LBF_OFF_CRC 12'h020
// ==========================================
// fields and reset values
`define LBF_CTRL_RUN 0
`define LBF_CTRL_AUTO 1
`define LBF_CTRL_RXRQ 2
`define LBF_TXC_SOP 8
`define LBF_TXC_EOP 9
`define LBF_LANES 4
`define LBF_MAXB_RST 8'h10
`define LBF_MAXB_MIN 8'h02
`define LBF_ST_OVF 0
`define LBF_ST_UFL 1
`define LBF_ST_BRST 2
`define LBF_ST_RXERR 3
`define LBF_ST_RXOVF 4
`define LBF_ST_CRC24 5
`endif

// *** hdl/lbf_ctrl.sv ***
`timescale 1ns/100ps
`include "lbf_consts.svh"
module lbf_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic core_reset,
   output logic gt_reset,
   output logic transceiver_receive_reset,
   output logic tx_ena,
   output logic [31:0] tx_data,
   output logic tx_sop,
   output logic tx_eop,
   output logic [7:0] tx_chan,
   output logic tx_bctl,
   input wire logic tx_rdy,
   input wire logic tx_ovf,
   input wire logic tx_underflow,
   input wire logic tx_burst_err,
   input wire logic rx_ena,
   input wire logic [31:0] rx_data,
   input wire logic rx_sop,
   input wire logic rx_eop,
   input wire logic rx_err,
   input wire logic rx_ovf,
   input wire logic [`LBF_LANES-1:0] lane_crc_mismatch_flag,
   input wire logic rx_crc24_err,
   input wire logic clk_stable,
   input wire logic clock_data_recovery_lock,
   input wire logic serial_data_valid
);
   // ==========================================
   // pin synchronisers
   logic [2:0] sync1_q, sync2_q;
   logic clk_s, cdr_s, ser_s, cdr_prev_q, ser_prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         cdr_prev_q <= 1'b0;
         ser_prev_q <= 1'b0;
      end else begin
         sync1_q <= {serial_data_valid, clock_data_recovery_lock, clk_stable};
         sync2_q <= sync1_q;
         cdr_prev_q <= sync2_q[1];
         ser_prev_q <= sync2_q[2];
      end
   end
   assign clk_s = sync2_q[0];
   assign cdr_s = sync2_q[1];
   assign ser_s = sync2_q[2];

   // ==========================================
   // apb decode
   logic acc, wr, rd, txc_wr, pend_q;
   logic [2:0] ctrl_q;
   logic [7:0] maxb_q;
   logic [31:0] txd_q, rxd_q;
   logic [5:0] stat_q;
   logic [`LBF_LANES-1:0] crc_q;
   logic [10:0] rxi_q;
   lbf_pkg::lbf_state_t st_q;
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign txc_wr = wr && paddr == `LBF_OFF_TXC;
   // a word still waiting for tx ready stalls the next one on the bus
   assign pready = !(psel && penable && pwrite && paddr == `LBF_OFF_TXC && pend_q);

   always_comb begin
      prdata = 32'h0;
      pslverr = 1'b0;
      case (paddr)
         `LBF_OFF_CTRL: prdata = {29'h0, ctrl_q};
         `LBF_OFF_MAXB: prdata = {24'h0, maxb_q};
         `LBF_OFF_TXD: prdata = txd_q;
         `LBF_OFF_TXC: prdata = 32'h0;
         `LBF_OFF_STAT: prdata = {26'h0, stat_q};
         `LBF_OFF_STATE: prdata = {28'h0, pend_q, tx_rdy, st_q};
         `LBF_OFF_RXD: prdata = rxd_q;
         `LBF_OFF_RXI: prdata = {21'h0, rxi_q};
         `LBF_OFF_CRC: prdata = {{(32-`LBF_LANES){1'b0}}, crc_q};
         default: pslverr = acc;
      endcase
   end

   // ==========================================
   // control registers
   logic rxrq_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 3'h0;
         rxrq_q <= 1'b0;
      end else begin
         rxrq_q <= wr && paddr == `LBF_OFF_CTRL && pwdata[`LBF_CTRL_RXRQ];
         if (wr && paddr == `LBF_OFF_CTRL)
            ctrl_q <= {1'b0, pwdata[`LBF_CTRL_AUTO], pwdata[`LBF_CTRL_RUN]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maxb_q <= `LBF_MAXB_RST;
      end else if (wr && paddr == `LBF_OFF_MAXB && st_q == lbf_pkg::LBF_HOLD &&
                   pwdata[7:0] >= `LBF_MAXB_MIN) begin
         maxb_q <= pwdata[7:0];
      end
   end

   // ==========================================
   // reset sequencer
   logic [7:0] cnt_rst_q;
   logic fault;
   // the device flags are on this clock, so they are read without synchronisers
   assign fault = !clk_s || (cdr_prev_q && !cdr_s) || (tx_ovf && ctrl_q[`LBF_CTRL_AUTO]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= lbf_pkg::LBF_HOLD;
         cnt_rst_q <= 8'h0;
      end else begin
         case (st_q)
            lbf_pkg::LBF_HOLD: begin
               if (clk_s && cdr_s && ctrl_q[`LBF_CTRL_RUN]) begin
                  cnt_rst_q <= cnt_rst_q + 8'h1;
                  if (cnt_rst_q == 8'(`LBF_RST_HOLD_CYC - 1)) begin
                     st_q <= lbf_pkg::LBF_RXRST;
                     cnt_rst_q <= 8'h0;
                  end
               end else begin
                  cnt_rst_q <= 8'h0;
               end
            end
            lbf_pkg::LBF_RXRST: begin
               if (fault || !ctrl_q[`LBF_CTRL_RUN]) begin
                  st_q <= lbf_pkg::LBF_HOLD;
                  cnt_rst_q <= 8'h0;
               end else if (ser_s) begin
                  cnt_rst_q <= cnt_rst_q + 8'h1;
                  if (cnt_rst_q == 8'(`LBF_RXRST_CYC - 1)) begin
                     st_q <= lbf_pkg::LBF_RUN;
                     cnt_rst_q <= 8'h0;
                  end
               end
            end
            lbf_pkg::LBF_RUN: begin
               if (fault || !ctrl_q[`LBF_CTRL_RUN]) begin
                  st_q <= lbf_pkg::LBF_HOLD;
               end else if ((ser_s && !ser_prev_q) || rxrq_q) begin
                  st_q <= lbf_pkg::LBF_RXRST;
               end
            end
            default: st_q <= lbf_pkg::LBF_HOLD;
         endcase
      end
   end
   assign core_reset = st_q == lbf_pkg::LBF_HOLD;
   assign gt_reset = st_q == lbf_pkg::LBF_HOLD;
   // receive-only reset leaves core_reset and gt_reset low, but tx words are not issued until LBF_RUN
   assign transceiver_receive_reset = st_q == lbf_pkg::LBF_RXRST;

   // ==========================================
   // tx writer with early forced control words
   logic [7:0] bcnt_q, chan_last_q;
   logic [9:0] txc_q;
   logic issue, chg, plain, force_bcw, tx_chg_q;
   assign issue = pend_q && tx_rdy && st_q == lbf_pkg::LBF_RUN;
   assign chg = txc_q[7:0] != chan_last_q;
   assign plain = !txc_q[`LBF_TXC_SOP] && !txc_q[`LBF_TXC_EOP] && !chg;
   // force one word ahead so the max length is never reached by itself
   assign force_bcw = plain && ({1'b0, bcnt_q} + 9'h2 >= {1'b0, maxb_q});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
         txd_q <= 32'h0;
         txc_q <= 10'h0;
      end else begin
         if (wr && paddr == `LBF_OFF_TXD)
            txd_q <= pwdata;
         if (issue)
            pend_q <= 1'b0;
         if (txc_wr) begin
            pend_q <= 1'b1;
            txc_q <= pwdata[9:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ena <= 1'b0;
         tx_data <= 32'h0;
         tx_sop <= 1'b0;
         tx_eop <= 1'b0;
         tx_chan <= 8'h0;
         tx_bctl <= 1'b0;
         tx_chg_q <= 1'b0;
         bcnt_q <= 8'h0;
         chan_last_q <= 8'h0;
      end else begin
         tx_ena <= issue;
         if (issue) begin
            tx_data <= txd_q;
            tx_sop <= txc_q[`LBF_TXC_SOP];
            tx_eop <= txc_q[`LBF_TXC_EOP];
            tx_chan <= txc_q[7:0];
            tx_bctl <= force_bcw;
            tx_chg_q <= chg;
            chan_last_q <= txc_q[7:0];
            // every implied or forced control word restarts the burst
            bcnt_q <= (plain && !force_bcw) ? bcnt_q + 8'h1 : 8'h0;
         end
         if (core_reset)
            bcnt_q <= 8'h0;
      end
   end

   // ==========================================
   // status capture, write one to clear, set wins
   logic [5:0] ev;
   assign ev = {rx_crc24_err, rx_ovf, rx_ena && rx_err, tx_burst_err, tx_underflow, tx_ovf};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= 6'h0;
         crc_q <= '0;
         rxd_q <= 32'h0;
         rxi_q <= 11'h0;
      end else begin
         stat_q <= (stat_q & ~((wr && paddr == `LBF_OFF_STAT) ? pwdata[5:0] : 6'h0))
                   | ev;
         crc_q <= (crc_q & ~((wr && paddr == `LBF_OFF_CRC) ? pwdata[`LBF_LANES-1:0] : '0))
                  | lane_crc_mismatch_flag;
         // the rx bus is taken every cycle, no stall toward the device
         if (rx_ena) begin
            rxd_q <= rx_data;
            rxi_q <= {rx_err, rx_eop, rx_sop, rxi_q[7:0] + 8'h1};
         end
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence run_fault_s;
      st_q == lbf_pkg::LBF_RUN && fault;
   endsequence
   sequence rx_wait_s;
      st_q == lbf_pkg::LBF_RXRST && !ser_s && !fault && ctrl_q[`LBF_CTRL_RUN];
   endsequence

   tx_rdy_gate_a: assert property (
      tx_ena |-> $past(tx_rdy) && !$past(core_reset))
      else $error("tx word issued without tx ready");
   one_bcw_a: assert property (
      tx_ena && tx_bctl |-> !tx_sop && !tx_eop && !tx_chg_q)
      else $error("forced control word coincides with implied one");
   max_unreached_a: assert property (
      tx_ena |-> bcnt_q + 8'h1 < maxb_q)
      else $error("burst reached max length");
   hold_reset_a: assert property (
      !clk_s |=> core_reset && gt_reset)
      else $error("reset released with unstable clock");
   fault_reset_a: assert property (
      run_fault_s |=> core_reset ##1 core_reset)
      else $error("instability did not reset core");
   ovf_reset_a: assert property (
      st_q == lbf_pkg::LBF_RUN && tx_ovf && ctrl_q[`LBF_CTRL_AUTO] |=> core_reset)
      else $error("overrun did not reset core");
   rx_reset_hold_a: assert property (
      rx_wait_s |=> transceiver_receive_reset && !core_reset)
      else $error("receive reset dropped before serial data valid");
   maxb_lock_a: assert property (
      !core_reset |=> $stable(maxb_q))
      else $error("max burst changed outside reset");
   crc24_sticky_a: assert property (
      rx_crc24_err |=> stat_q[`LBF_ST_CRC24])
      else $error("crc24 error not captured");
endmodule : lbf_ctrl

// *** hdl/lbf_pkg.sv ***
package lbf_pkg;
   typedef enum logic [1:0] {LBF_HOLD, LBF_RXRST, LBF_RUN} lbf_state_t;
endpackage : lbf_pkg
